// *** design/dpc_pkg.sv ***
package dpc_pkg;

    // Access port addresses of the misc debug unit
    localparam logic [31:0] DPC_STATUS_ADDR = 32'h0100_0000;
    localparam logic [31:0] DPC_CTRL_ADDR = 32'h0100_0004;
    localparam logic [31:0] DPC_IDENT_ADDR = 32'h0100_00FC;

    // Identification value; arbitrary neutral value
    localparam logic [31:0] DPC_IDENT_VALUE = 32'h0000_0A5A;

    // Control register field positions
    localparam int unsigned DPC_C_ERASE = 0;
    localparam int unsigned DPC_C_DBG_DIS = 1;
    localparam int unsigned DPC_C_DBG_REQ = 2;
    localparam int unsigned DPC_C_RST_REQ = 3;
    localparam int unsigned DPC_C_HOLD = 4;
    localparam int unsigned DPC_C_WIDTH = 5;

    // Status register field positions
    localparam int unsigned DPC_S_ERASE_ACK = 0;
    localparam int unsigned DPC_S_FLASH_RDY = 1;
    localparam int unsigned DPC_S_SECURE = 2;
    localparam int unsigned DPC_S_NOT_RST = 3;
    localparam int unsigned DPC_S_HALTED = 16;
    localparam int unsigned DPC_S_SLEEPDEEP = 17;
    localparam int unsigned DPC_S_SLEEPING = 18;

    // Reset values
    localparam logic [31:0] DPC_ZERO_WORD = 32'h0000_0000;
    localparam logic [DPC_C_WIDTH-1:0] DPC_CTRL_RESET = 5'h00;

    // Widths of the two crossing vectors
    localparam int unsigned DPC_L2S_WIDTH = 6;
    localparam int unsigned DPC_S2L_WIDTH = 8;

    // Software reset pulse length
    localparam int unsigned DPC_CLK_HZ = 25000000;
    localparam int unsigned DPC_SW_RESET_NS = 640;
    localparam logic [7:0] DPC_SW_RESET_CYCLES = 8'(
        (DPC_SW_RESET_NS * (DPC_CLK_HZ / 1000000) + 999) / 1000);

endpackage : dpc_pkg

// *** design/dpc_level_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Three-stage level synchroniser; a bit moves once stages two and
// three agree, so a single metastable sample never reaches the output
module dpc_level_sync #(
    parameter int unsigned W = 1
) (
    // Destination clock and power-on reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Levels from the other domain and their settled copy
    input wire logic [W-1:0] level_i,
    output logic [W-1:0] level_o
);

    // All state of the synchroniser
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] out;
    } dpc_sync_type;

    dpc_sync_type s_q;
    dpc_sync_type s_d;

    // Shift and accept a bit only when two later stages agree
    always_comb
    begin
        s_d = s_q;
        s_d.ff1 = level_i;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        for (int i = 0; i < W; i++)
        begin
            if (s_q.ff2[i] == s_q.ff3[i])
            begin
                s_d.out[i] = s_q.ff3[i];
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.out;

endmodule : dpc_level_sync

`default_nettype wire

// *** design/dpc_debug_port_control.sv ***
`timescale 1ns/10ps
`default_nettype none

module dpc_debug_port_control (
    // System clock and power-on reset (the only reset here)
    input wire logic clk_i,
    input wire logic resetn_i,
    // Access port link, on the debugger's own clock
    input wire logic ap_clk_i,
    input wire logic ap_wr_i,
    input wire logic ap_rd_i,
    input wire logic [31:0] ap_addr_i,
    input wire logic [31:0] ap_wdata_i,
    input wire logic ap_session_i,
    output logic [31:0] ap_rdata_o,
    output logic ap_ack_o,
    // Flash controller, system clock
    input wire logic flash_ready_i,
    input wire logic flash_erase_started_i,
    input wire logic flash_erase_done_i,
    input wire logic secure_i,
    output logic flash_erase_start_o,
    // Core and system state, system clock
    input wire logic sys_in_reset_i,
    input wire logic core_halted_i,
    input wire logic core_sleepdeep_i,
    input wire logic core_sleeping_i,
    input wire logic chip_low_power_i,
    input wire logic software_system_reset_request_i,
    // Controls to core and system
    output logic core_debug_force_off_o,
    output logic core_halt_req_o,
    output logic chip_wake_o,
    output logic sys_reset_o,
    output logic reset_pin_low_o,
    output logic core_reset_hold_o,
    output logic low_power_block_o
);

    // Link domain state: control register, ack flag and read port
    typedef struct packed {
        logic [dpc_pkg::DPC_C_WIDTH-1:0] ctrl;
        logic erase_ack;
        logic erase_tgl;
        logic start_seen;
        logic done_seen;
        logic [31:0] rdata;
        logic ack;
    } dpc_link_type;

    // System domain state: event toggles and registered controls
    typedef struct packed {
        logic erase_seen;
        logic start_tgl;
        logic done_tgl;
        logic erase_start;
        logic force_off;
        logic halt_req;
        logic wake;
        logic sys_reset;
        logic pin_low;
        logic core_held;
        logic lp_block;
        logic in_reset_prev;
        logic [7:0] sw_cnt;
    } dpc_sys_type;

    dpc_link_type l_q;
    dpc_link_type l_d;
    dpc_sys_type s_q;
    dpc_sys_type s_d;

    // Crossing vectors and their settled copies
    logic [dpc_pkg::DPC_L2S_WIDTH-1:0] l2s_src;
    logic [dpc_pkg::DPC_L2S_WIDTH-1:0] l2s_dst;
    logic [dpc_pkg::DPC_S2L_WIDTH-1:0] s2l_src;
    logic [dpc_pkg::DPC_S2L_WIDTH-1:0] s2l_dst;

    // Settled control levels in the system domain
    logic c_erase_tgl;
    logic c_dbg_dis;
    logic c_dbg_req;
    logic c_rst_req;
    logic c_hold;
    logic c_session;

    // Settled status levels in the link domain
    logic st_ready;
    logic st_secure;
    logic st_not_rst;
    logic st_halted;
    logic st_deep;
    logic st_sleep;
    logic st_start_tgl;
    logic st_done_tgl;

    // Address match helper, used by both read and write decode
    function automatic logic dpc_hit(input logic [31:0] a,
                                     input logic [31:0] b);
        dpc_hit = (a == b);
    endfunction : dpc_hit

    // Link to system: session, every control level but erase, and the erase toggle
    assign l2s_src = {ap_session_i,
                      l_q.ctrl[dpc_pkg::DPC_C_HOLD],
                      l_q.ctrl[dpc_pkg::DPC_C_RST_REQ],
                      l_q.ctrl[dpc_pkg::DPC_C_DBG_REQ],
                      l_q.ctrl[dpc_pkg::DPC_C_DBG_DIS],
                      l_q.erase_tgl};
    assign {c_session, c_hold, c_rst_req, c_dbg_req, c_dbg_dis,
            c_erase_tgl} = l2s_dst;

    // System to link: status levels and flash event toggles
    assign s2l_src = {s_q.done_tgl, s_q.start_tgl, core_sleeping_i,
                      core_sleepdeep_i, core_halted_i, ~sys_in_reset_i,
                      secure_i, flash_ready_i};
    assign {st_done_tgl, st_start_tgl, st_sleep, st_deep, st_halted,
            st_not_rst, st_secure, st_ready} = s2l_dst;

    // Controls into the system clock domain
    dpc_level_sync #(
        .W(dpc_pkg::DPC_L2S_WIDTH)
    ) u_sync_to_sys (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .level_i(l2s_src),
        .level_o(l2s_dst)
    );

    // Status into the link clock domain
    dpc_level_sync #(
        .W(dpc_pkg::DPC_S2L_WIDTH)
    ) u_sync_to_link (
        .clk_i(ap_clk_i),
        .resetn_i(resetn_i),
        .level_i(s2l_src),
        .level_o(s2l_dst)
    );

    // Link domain: register writes, reads and flash event handling
    always_comb
    begin
        logic start_ev;
        logic done_ev;
        start_ev = st_start_tgl ^ l_q.start_seen;
        done_ev = st_done_tgl ^ l_q.done_seen;
        l_d = l_q;
        l_d.ack = ap_wr_i | ap_rd_i;
        l_d.start_seen = st_start_tgl;
        l_d.done_seen = st_done_tgl;
        // Flash finished the erase: drop the in-progress bit
        if (done_ev)
        begin
            l_d.ctrl[dpc_pkg::DPC_C_ERASE] = 1'b0;
        end
        // Control write; bits above the control field are ignored
        if (ap_wr_i && dpc_hit(ap_addr_i, dpc_pkg::DPC_CTRL_ADDR))
        begin
            // New launch only when no erase is already running
            if (ap_wdata_i[dpc_pkg::DPC_C_ERASE] &&
                !l_q.ctrl[dpc_pkg::DPC_C_ERASE])
            begin
                l_d.ctrl[dpc_pkg::DPC_C_ERASE] = 1'b1;
                l_d.erase_tgl = ~l_q.erase_tgl;
                l_d.erase_ack = 1'b0;
            end
            // Reset request is honoured in every security state
            l_d.ctrl[dpc_pkg::DPC_C_RST_REQ] =
                ap_wdata_i[dpc_pkg::DPC_C_RST_REQ];
            // Remaining commands only work on an unsecured part
            if (!st_secure)
            begin
                l_d.ctrl[dpc_pkg::DPC_C_DBG_DIS] =
                    ap_wdata_i[dpc_pkg::DPC_C_DBG_DIS];
                l_d.ctrl[dpc_pkg::DPC_C_DBG_REQ] =
                    ap_wdata_i[dpc_pkg::DPC_C_DBG_REQ];
                l_d.ctrl[dpc_pkg::DPC_C_HOLD] =
                    ap_wdata_i[dpc_pkg::DPC_C_HOLD];
            end
        end
        // Securing the part cancels any command it forbids
        if (st_secure)
        begin
            l_d.ctrl[dpc_pkg::DPC_C_DBG_DIS] = 1'b0;
            l_d.ctrl[dpc_pkg::DPC_C_DBG_REQ] = 1'b0;
            l_d.ctrl[dpc_pkg::DPC_C_HOLD] = 1'b0;
        end
        // Start seen by flash sets the ack; set wins over the clear
        if (start_ev)
        begin
            l_d.erase_ack = 1'b1;
        end
        // Read mux; status stays readable while secured
        l_d.rdata = dpc_pkg::DPC_ZERO_WORD;
        if (ap_rd_i)
        begin
            if (dpc_hit(ap_addr_i, dpc_pkg::DPC_STATUS_ADDR))
            begin
                l_d.rdata[dpc_pkg::DPC_S_ERASE_ACK] = l_q.erase_ack;
                l_d.rdata[dpc_pkg::DPC_S_FLASH_RDY] = st_ready;
                l_d.rdata[dpc_pkg::DPC_S_SECURE] = st_secure;
                l_d.rdata[dpc_pkg::DPC_S_NOT_RST] = st_not_rst;
                l_d.rdata[dpc_pkg::DPC_S_HALTED] = st_halted;
                l_d.rdata[dpc_pkg::DPC_S_SLEEPDEEP] = st_deep;
                l_d.rdata[dpc_pkg::DPC_S_SLEEPING] = st_sleep;
            end
            else if (dpc_hit(ap_addr_i, dpc_pkg::DPC_CTRL_ADDR))
            begin
                // Reserved upper bits read zero
                l_d.rdata[dpc_pkg::DPC_C_WIDTH-1:0] = l_q.ctrl;
            end
            else if (dpc_hit(ap_addr_i, dpc_pkg::DPC_IDENT_ADDR))
            begin
                l_d.rdata = dpc_pkg::DPC_IDENT_VALUE;
            end
        end
    end

    // Link registers; only power-on reset clears the debug logic
    always_ff @(posedge ap_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            l_q <= '0;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    assign ap_rdata_o = l_q.rdata;
    assign ap_ack_o = l_q.ack;

    // System domain: turn settled controls into core and reset lines
    always_comb
    begin
        logic sys_hold;
        sys_hold = c_hold & ~secure_i;
        s_d = s_q;
        s_d.in_reset_prev = sys_in_reset_i;
        // Erase launch toggle becomes a one-cycle start pulse
        s_d.erase_seen = c_erase_tgl;
        s_d.erase_start = c_erase_tgl ^ s_q.erase_seen;
        // Flash events go back to the link as toggles
        if (flash_erase_started_i)
        begin
            s_d.start_tgl = ~s_q.start_tgl;
        end
        if (flash_erase_done_i)
        begin
            s_d.done_tgl = ~s_q.done_tgl;
        end
        // Secured parts ignore disable, halt and hold locally too
        s_d.force_off = c_dbg_dis & ~secure_i;
        s_d.halt_req = c_dbg_req & ~secure_i;
        // A halt request also wakes a sleeping core or chip
        s_d.wake = c_dbg_req & ~secure_i &
            (core_sleepdeep_i | core_sleeping_i |
             chip_low_power_i);
        // Active session keeps the chip out of low power unless debug is forced off; a static
        // debug port then simply carries on when the mode ends
        s_d.lp_block = c_session & ~s_d.force_off;
        // Software reset request starts a fixed-length reset
        if (software_system_reset_request_i)
        begin
            s_d.sw_cnt = dpc_pkg::DPC_SW_RESET_CYCLES;
        end
        else if (s_q.sw_cnt != 8'h00)
        begin
            s_d.sw_cnt = s_q.sw_cnt - 8'h01;
        end
        s_d.sys_reset = c_rst_req | (s_d.sw_cnt != 8'h00);
        // Reset pin is driven only for resets the debugger did not ask
        s_d.pin_low = s_d.sys_reset & ~c_rst_req;
        // Hold sampled at end of reset sequencing; a clear releases
        if (s_q.in_reset_prev && !sys_in_reset_i)
        begin
            s_d.core_held = sys_hold;
        end
        else if (!sys_hold)
        begin
            s_d.core_held = 1'b0;
        end
    end

    // System registers; its own resets never touch this logic
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign flash_erase_start_o = s_q.erase_start;
    assign core_debug_force_off_o = s_q.force_off;
    assign core_halt_req_o = s_q.halt_req;
    assign chip_wake_o = s_q.wake;
    assign sys_reset_o = s_q.sys_reset;
    assign reset_pin_low_o = s_q.pin_low;
    assign core_reset_hold_o = s_q.core_held;
    assign low_power_block_o = s_q.lp_block;

    // Erase launch: bit set and ack cleared the cycle after the write
    a_erase_launch: assert property (@(posedge ap_clk_i)
        disable iff (!resetn_i)
        ap_wr_i && dpc_hit(ap_addr_i, dpc_pkg::DPC_CTRL_ADDR) &&
        ap_wdata_i[dpc_pkg::DPC_C_ERASE] &&
        !l_q.ctrl[dpc_pkg::DPC_C_ERASE] &&
        !(st_start_tgl ^ l_q.start_seen)
        |=> l_q.ctrl[dpc_pkg::DPC_C_ERASE] && !l_q.erase_ack)
        else $error("erase launch not recorded");

    // Done event clears the erase bit
    a_erase_done: assert property (@(posedge ap_clk_i)
        disable iff (!resetn_i)
        (st_done_tgl != l_q.done_seen)
        |=> !l_q.ctrl[dpc_pkg::DPC_C_ERASE])
        else $error("erase bit not cleared on done");

    // Start event sets the ack
    a_ack_set: assert property (@(posedge ap_clk_i)
        disable iff (!resetn_i)
        (st_start_tgl != l_q.start_seen) |=> l_q.erase_ack)
        else $error("erase ack not set on start");

    // Secured part never holds a debug request or core hold
    a_secure_mask: assert property (@(posedge ap_clk_i)
        disable iff (!resetn_i)
        st_secure ##1 st_secure |->
        l_q.ctrl[dpc_pkg::DPC_C_DBG_REQ] == 1'b0 &&
        l_q.ctrl[dpc_pkg::DPC_C_HOLD] == 1'b0)
        else $error("forbidden command kept while secured");

    // Status read answers next cycle with the security flag
    a_status_read: assert property (@(posedge ap_clk_i)
        disable iff (!resetn_i)
        ap_rd_i && dpc_hit(ap_addr_i, dpc_pkg::DPC_STATUS_ADDR)
        |=> ap_ack_o &&
        ap_rdata_o[dpc_pkg::DPC_S_SECURE] == $past(st_secure))
        else $error("status read wrong");

    // Debugger reset request holds system reset, pin left alone
    a_rst_hold: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        c_rst_req |=> sys_reset_o && !reset_pin_low_o)
        else $error("reset request not honoured");

    // Software request gives reset and drives the pin
    a_sw_reset: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        software_system_reset_request_i && !c_rst_req ##1 !c_rst_req
        |-> sys_reset_o && reset_pin_low_o)
        else $error("software reset missing");

    // Disable bit forces debug off within one cycle
    a_force_off: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        c_dbg_dis && !secure_i |=> core_debug_force_off_o)
        else $error("debug not forced off");

    // Halt request wakes a sleeping core
    a_halt_wake: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        c_dbg_req && !secure_i && core_sleeping_i
        |=> core_halt_req_o && chip_wake_o)
        else $error("halt request did not wake core");

    // Clearing hold releases the core at once
    a_hold_release: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        core_reset_hold_o && !c_hold |=> !core_reset_hold_o)
        else $error("core not released");

    // Active session blocks low power
    a_lp_block: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        c_session && !c_dbg_dis |=> low_power_block_o)
        else $error("low power not blocked");

    // Main scenarios
    c_erase_flow: cover property (@(posedge clk_i)
        disable iff (!resetn_i)
        flash_erase_start_o ##[1:400] flash_erase_done_i);
    c_core_hold: cover property (@(posedge clk_i)
        disable iff (!resetn_i)
        core_reset_hold_o ##[1:50] !core_reset_hold_o);
    c_halt_wake: cover property (@(posedge clk_i)
        disable iff (!resetn_i) chip_wake_o);
    c_secure_read: cover property (@(posedge ap_clk_i)
        disable iff (!resetn_i) st_secure && ap_rd_i);

endmodule : dpc_debug_port_control

`default_nettype wire

// *** sim/dpc_probe_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Debugger probe: one access port request per call, on the link clock
module dpc_probe_model (
    // Link clock from the bench
    input wire logic ap_clk_i,
    // Answer from the device
    input wire logic [31:0] ap_rdata_i,
    input wire logic ap_ack_i,
    // Request towards the device
    output logic ap_wr_o,
    output logic ap_rd_o,
    output logic [31:0] ap_addr_o,
    output logic [31:0] ap_wdata_o
);

    // Idle bus at time zero
    initial
    begin
        ap_wr_o = 1'b0;
        ap_rd_o = 1'b0;
        ap_addr_o = 32'h0000_0000;
        ap_wdata_o = 32'h0000_0000;
    end

    // One-cycle strobe, then inverted address and data once released,
    // so a device that samples late never sees a stale match
    task automatic access(input logic wr, input logic [31:0] addr,
                          input logic [31:0] data,
                          output logic [31:0] rdata, output logic acked);
        int n;
        acked = 1'b0;
        rdata = 32'h0000_0000;
        @(posedge ap_clk_i);
        ap_wr_o <= wr;
        ap_rd_o <= ~wr;
        ap_addr_o <= addr;
        ap_wdata_o <= data;
        @(posedge ap_clk_i);
        ap_wr_o <= 1'b0;
        ap_rd_o <= 1'b0;
        ap_addr_o <= ~addr;
        ap_wdata_o <= ~data;
        // Answer is a one-cycle pulse; take it at the edge that samples it
        for (n = 0; n < 4 && !acked; n++)
        begin
            @(posedge ap_clk_i);
            if (ap_ack_i === 1'b1)
            begin
                acked = 1'b1;
                rdata = ap_rdata_i;
            end
        end
    endtask : access

endmodule : dpc_probe_model

`default_nettype wire

// *** sim/dpc_debug_port_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module dpc_debug_port_control_test;

    localparam logic [31:0] ST = dpc_pkg::DPC_STATUS_ADDR;
    localparam logic [31:0] CT = dpc_pkg::DPC_CTRL_ADDR;

    // Clocks, reset and all design inputs
    logic clk_i = 1'b0;
    logic ap_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ap_session_i = 1'b0;
    logic flash_ready_i = 1'b1;
    logic flash_erase_started_i = 1'b0;
    logic flash_erase_done_i = 1'b0;
    logic secure_i = 1'b0;
    logic sys_in_reset_i = 1'b0;
    logic core_halted_i = 1'b0;
    logic core_sleepdeep_i = 1'b0;
    logic core_sleeping_i = 1'b0;
    logic chip_low_power_i = 1'b0;
    logic sw_rst_i = 1'b0;
    // Link wires and design outputs
    logic ap_wr, ap_rd, ap_ack;
    logic [31:0] ap_addr, ap_wdata, ap_rdata;
    logic erase_start, force_off, halt_req, wake, sys_reset;
    logic pin_low, hold, lp_block;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] r;
    int n;

    // System clock, 40 ns; link clock 160 ns on an odd phase
    always #20 clk_i = ~clk_i;
    initial
    begin
        #7;
        forever #80 ap_clk_i = ~ap_clk_i;
    end

    dpc_probe_model i_probe (.ap_clk_i(ap_clk_i), .ap_rdata_i(ap_rdata),
        .ap_ack_i(ap_ack), .ap_wr_o(ap_wr), .ap_rd_o(ap_rd),
        .ap_addr_o(ap_addr), .ap_wdata_o(ap_wdata));

    dpc_debug_port_control i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .ap_clk_i(ap_clk_i), .ap_wr_i(ap_wr), .ap_rd_i(ap_rd),
        .ap_addr_i(ap_addr), .ap_wdata_i(ap_wdata),
        .ap_session_i(ap_session_i), .ap_rdata_o(ap_rdata),
        .ap_ack_o(ap_ack), .flash_ready_i(flash_ready_i),
        .flash_erase_started_i(flash_erase_started_i),
        .flash_erase_done_i(flash_erase_done_i), .secure_i(secure_i),
        .flash_erase_start_o(erase_start), .sys_in_reset_i(sys_in_reset_i),
        .core_halted_i(core_halted_i), .core_sleepdeep_i(core_sleepdeep_i),
        .core_sleeping_i(core_sleeping_i),
        .chip_low_power_i(chip_low_power_i),
        .software_system_reset_request_i(sw_rst_i),
        .core_debug_force_off_o(force_off), .core_halt_req_o(halt_req),
        .chip_wake_o(wake), .sys_reset_o(sys_reset),
        .reset_pin_low_o(pin_low), .core_reset_hold_o(hold),
        .low_power_block_o(lp_block));

    // Counts every compare, reports a mismatch at once
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic chk1(input string nm, input logic s, input logic e);
        check(nm, {31'h0, s}, {31'h0, e});
    endtask : chk1

    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask : tick

    // Register access through the probe; a missing answer is a mismatch
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        logic k;
        i_probe.access(w, a, d, q, k);
        chk1("ack", k, 1'b1);
    endtask : acc

    // Write, then give the control levels time to cross (10 clk)
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
        tick(10);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [31:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        repeat (6) @(posedge ap_clk_i);
        acc(1'b0, a, 32'h0000_0000, q);
        check(nm, q, e);
    endtask : rd_chk

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        tick(16);
        resetn_i <= 1'b1;
        @(posedge ap_clk_i);
        ap_session_i <= 1'b1;
        rd_chk("ctrl after por", CT, 32'h0000_0000);
        rd_chk("status", ST, 32'h0000_000A);
        rd_chk("ident", 32'h0100_00FC, dpc_pkg::DPC_IDENT_VALUE);
        rd_chk("unmapped", 32'h0100_0008, 32'h0000_0000);
        chk1("lp block", lp_block, 1'b1);
        // Reserved bits have no effect
        wr(CT, 32'hFFFF_FFE0);
        rd_chk("reserved", CT, 32'h0000_0000);
        chk1("no reset", sys_reset, 1'b0);
        // Debug disable overrides session
        wr(CT, 32'h0000_0002);
        chk1("force off", force_off, 1'b1);
        chk1("lp block off", lp_block, 1'b0);
        wr(CT, 32'h0000_0000);
        chk1("force off clr", force_off, 1'b0);
        // Debug request on a sleeping core, then chip low power
        core_sleeping_i <= 1'b1;
        wr(CT, 32'h0000_0004);
        chk1("halt", halt_req, 1'b1);
        chk1("wake core", wake, 1'b1);
        @(posedge clk_i);
        core_sleeping_i <= 1'b0;
        chip_low_power_i <= 1'b1;
        tick(4);
        chk1("wake chip", wake, 1'b1);
        chip_low_power_i <= 1'b0;
        // Core and system levels must show up in the status word
        core_halted_i <= 1'b1;
        core_sleepdeep_i <= 1'b1;
        core_sleeping_i <= 1'b1;
        flash_ready_i <= 1'b0;
        sys_in_reset_i <= 1'b1;
        rd_chk("status core", ST, 32'h0007_0000);
        @(posedge clk_i);
        core_halted_i <= 1'b0;
        core_sleepdeep_i <= 1'b0;
        core_sleeping_i <= 1'b0;
        flash_ready_i <= 1'b1;
        sys_in_reset_i <= 1'b0;
        wr(CT, 32'h0000_0000);
        chk1("halt clr", halt_req | wake, 1'b0);
        rd_chk("after lp", CT, 32'h0000_0000);
        // Reset request holds reset without the pin
        wr(CT, 32'h0000_0008);
        tick(40);
        chk1("sys reset", sys_reset, 1'b1);
        chk1("pin", pin_low, 1'b0);
        wr(CT, 32'h0000_0000);
        chk1("sys reset clr", sys_reset, 1'b0);
        // Software reset request pulse
        sw_rst_i <= 1'b1;
        @(posedge clk_i);
        sw_rst_i <= 1'b0;
        @(negedge clk_i);
        chk1("sw reset", sys_reset & pin_low, 1'b1);
        tick(int'(dpc_pkg::DPC_SW_RESET_CYCLES) + 4);
        chk1("sw reset end", sys_reset | pin_low, 1'b0);
        // Core hold sampled at end of reset sequencing
        wr(CT, 32'h0000_0010);
        sys_in_reset_i <= 1'b1;
        rd_chk("ctrl in reset", CT, 32'h0000_0010);
        @(posedge clk_i);
        sys_in_reset_i <= 1'b0;
        tick(4);
        chk1("hold", hold, 1'b1);
        wr(CT, 32'h0000_0000);
        chk1("release", hold, 1'b0);
        // Mass erase launch, acknowledge and self-clear
        acc(1'b1, CT, 32'h0000_0001, r);
        r = 32'h0000_0000;
        for (n = 0; n < 40 && r == 0; n++)
        begin
            @(negedge clk_i);
            r = {31'h0, erase_start === 1'b1};
        end
        check("erase start", r, 32'h0000_0001);
        rd_chk("ack clear", ST, 32'h0000_000A);
        @(posedge clk_i);
        flash_erase_started_i <= 1'b1;
        @(posedge clk_i);
        flash_erase_started_i <= 1'b0;
        rd_chk("ack set", ST, 32'h0000_000B);
        rd_chk("in progress", CT, 32'h0000_0001);
        @(posedge clk_i);
        flash_erase_done_i <= 1'b1;
        @(posedge clk_i);
        flash_erase_done_i <= 1'b0;
        r = 32'h0000_0001;
        for (n = 0; n < 20 && r !== 32'h0000_0000; n++)
            acc(1'b0, CT, 32'h0000_0000, r);
        check("erase done", r, 32'h0000_0000);
        // Power-off recovery: debug logic returns cleared, then reconfigure
        wr(CT, 32'h0000_0010);
        resetn_i <= 1'b0;
        tick(16);
        resetn_i <= 1'b1;
        rd_chk("ctrl after recovery", CT, 32'h0000_0000);
        wr(CT, 32'h0000_0010);
        rd_chk("reconfigured", CT, 32'h0000_0010);
        wr(CT, 32'h0000_0000);
        // Secured: only erase and reset request remain
        @(posedge clk_i);
        secure_i <= 1'b1;
        wr(CT, 32'h0000_0016);
        rd_chk("secure ctrl", CT, 32'h0000_0000);
        chk1("secure halt", halt_req | force_off | wake, 1'b0);
        rd_chk("secure status", ST, 32'h0000_000E);
        wr(CT, 32'h0000_0008);
        chk1("secure reset", sys_reset, 1'b1);
        wr(CT, 32'h0000_0000);
        complete_run();
    end

endmodule : dpc_debug_port_control_test

`default_nettype wire
